// file: dv/prog_io_chip_model.sv
// Behavioural program memory with chip ports and four data-memory output ports.
// Assumes the core samples prog_data through its own synchronisers.
`timescale 1ns/10ps
`default_nettype none
module prog_io_chip_model (
  input wire logic ref_clk,
  input wire logic [11:0] prog_addr,
  output logic [7:0] prog_data,
  input wire logic [3:0] bus_out,
  input wire logic bus_oe_n,
  input wire logic address_subcycle_two,
  input wire logic port_wr,
  output logic [3:0] port_in
);
  logic [7:0] mem [0:4095];
  logic [3:0] in_port [0:15];
  logic [3:0] out_port [0:3];
  logic [3:0] sel_reg;
  logic [11:0] addr_q;
  initial
  begin
    sel_reg = 4'h0;
    foreach (in_port[i]) in_port[i] = 4'h0;
    foreach (out_port[i]) out_port[i] = 4'h0;
  end
  // Stale inverse for one cycle after the address moves, so early sampling shows up
  always @(posedge ref_clk) addr_q <= prog_addr;
  assign prog_data = (prog_addr == addr_q) ? mem[prog_addr] : ~mem[addr_q];
  assign port_in = in_port[sel_reg];
  always @(posedge ref_clk)
  begin
    if (address_subcycle_two && !bus_oe_n)
      sel_reg <= bus_out;
    for (int i = 0; i < 4; i++)
    begin
      if (port_wr && !bus_oe_n && sel_reg[3:2] == 2'(i))
        out_port[i] <= bus_out;
    end
  end
endmodule
`default_nettype wire

// file: dv/test_nibble_cpu_branch_io_exec.sv
// Self-checking bench for the nibble CPU execution core.
// Assumes the chip model answers fetches and ports; programs are poked into it.
`timescale 1ns/10ps
`default_nettype none
module test_nibble_cpu_branch_io_exec;
  logic ref_clk, srst, test_in;
  logic [7:0] prog_data;
  logic [3:0] port_in, bus_out, prog_chip, acc;
  logic [11:0] prog_addr;
  logic bus_oe_n, address_subcycle_two, address_subcycle_three, port_rd, port_wr, carry;
  logic [1:0] data_chip;
  int mismatches, cmp_count, cycles;

  nibble_cpu_branch_io_exec nibble_cpu_branch_io_exec_inst (.ref_clk(ref_clk), .srst(srst),
    .test_in(test_in), .prog_data(prog_data), .port_in(port_in), .prog_addr(prog_addr),
    .bus_out(bus_out), .bus_oe_n(bus_oe_n), .address_subcycle_two(address_subcycle_two),
    .address_subcycle_three(address_subcycle_three), .port_rd(port_rd), .port_wr(port_wr),
    .prog_chip(prog_chip), .data_chip(data_chip), .acc(acc), .carry(carry));
  prog_io_chip_model prog_io_chip_model_inst (.ref_clk(ref_clk), .prog_addr(prog_addr),
    .prog_data(prog_data), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
    .address_subcycle_two(address_subcycle_two), .port_wr(port_wr), .port_in(port_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Whole run needs about 500 cycles; the ceiling leaves wide margin
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      $display("ERROR timeout expected finish seen hang");
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (exp !== got)
    begin
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
      mismatches++;
    end
  endtask

  // Entries are {address, word}; everything else reads as a no-op
  task automatic load_and_reset(input logic [19:0] prog[$]);
    srst = 1'b1;
    for (int i = 0; i < 4096; i++) prog_io_chip_model_inst.mem[i] = 8'h00;
    foreach (prog[i]) prog_io_chip_model_inst.mem[prog[i][19:8]] = prog[i][7:0];
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
  endtask

  task automatic run_to(input logic [11:0] a);
    int n;
    n = 0;
    while (prog_addr !== a && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    check("prog_addr", a, prog_addr);
  endtask

  // Both targets hold an always-taken self jump, so the end address stays within the target's two words
  task automatic test_jump;
    logic [3:0] cond;
    logic [11:0] exp;
    for (int k = 0; k < 4; k++)
    begin
      cond = k[1] ? 4'h9 : 4'h1;
      test_in = k[0];
      exp = (cond[3] ^ ~test_in) ? 12'h010 : 12'h002;
      load_and_reset('{{12'h000, 4'h1, cond}, 20'h001_10, 20'h010_18, 20'h011_10,
        20'h002_18, 20'h003_02});
      repeat (40) @(negedge ref_clk);
      check("jump target", exp, {prog_addr[11:1], 1'b0});
    end
    $display("test jump done");
  endtask

  task automatic test_acc_loop;
    int n, hits;
    logic [11:0] prev;
    load_and_reset('{20'h000_D8, 20'h001_BF, 20'h002_D6, 20'h003_BE, 20'h004_D0,
      20'h005_8F, 20'h006_F5, 20'h007_F6, 20'h008_7E, 20'h009_08, 20'h00A_18, 20'h00B_0A});
    run_to(12'h001);
    check("acc", 12'h008, 12'(acc));
    run_to(12'h002);
    check("acc", 12'h000, 12'(acc));
    run_to(12'h006);
    check("acc", 12'h008, 12'(acc));
    run_to(12'h007);
    check("acc carry", 12'h010, {7'h00, carry, acc});
    run_to(12'h008);
    check("acc carry", 12'h008, {7'h00, carry, acc});
    n = 0;
    hits = 0;
    prev = prog_addr;
    while (prog_addr !== 12'h00A && n < 2000)
    begin
      @(negedge ref_clk);
      if (prog_addr === 12'h008 && prev !== 12'h008)
        hits++;
      prev = prog_addr;
      n++;
    end
    check("loop repeats", 12'h009, 12'(hits));
    check("acc", 12'h008, 12'(acc));
    $display("test acc_loop done");
  endtask

  // Skip loop at the page's last bytes must land in the next page
  task automatic test_page;
    load_and_reset('{20'h000_18, 20'h001_FE, 20'h0FE_7E, 20'h0FF_20, 20'h120_18,
      20'h121_20});
    run_to(12'h120);
    $display("test page done");
  endtask

  task automatic test_ports;
    int n;
    prog_io_chip_model_inst.in_port[12] = 4'hA;
    prog_io_chip_model_inst.in_port[0] = 4'h3;
    load_and_reset('{20'h000_20, 20'h001_C5, 20'h002_21, 20'h003_EA, 20'h004_D9,
      20'h005_E1, 20'h006_18, 20'h007_06});
    run_to(12'h002);
    n = 0;
    while (address_subcycle_two !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    check("first nibble", 12'h00C, {7'h00, bus_oe_n, bus_out});
    @(negedge ref_clk);
    check("second nibble", 12'h015, {7'h00, address_subcycle_three, bus_out});
    check("chips", 12'h0C3, {4'h0, prog_chip, 2'h0, data_chip});
    n = 0;
    while (port_rd !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    while (port_rd === 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    check("port_rd cycles", 12'h004, 12'(n));
    run_to(12'h004);
    check("acc", 12'h00A, 12'(acc));
    run_to(12'h006);
    repeat (2) @(negedge ref_clk);
    check("data port 3", 12'h009, 12'(prog_io_chip_model_inst.out_port[3]));
    check("data port 0", 12'h000, 12'(prog_io_chip_model_inst.out_port[0]));
    $display("test ports done");
  endtask

  initial
  begin
    srst = 1'b1;
    test_in = 1'b1;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (10) @(negedge ref_clk);
    test_jump();
    test_acc_loop();
    test_page();
    test_ports();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: logic/index_reg_file.sv
// Sixteen four-bit index registers with two registered read ports.
// Assumes the caller holds read addresses one cycle before using data.
`timescale 1ns/10ps
`default_nettype none
module index_reg_file #(
  parameter int DEPTH = 16,
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] rd_addr_a,
  input wire logic [3:0] rd_addr_b,
  output logic [W-1:0] rd_data_a,
  output logic [W-1:0] rd_data_b,
  input wire logic we,
  input wire logic pair,
  input wire logic [3:0] wr_addr,
  input wire logic [2*W-1:0] wr_data
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] cells;
    logic [W-1:0] rda;
    logic [W-1:0] rdb;
  } rf_s;

  rf_s rf_reg;
  rf_s rf_next;

  always_comb
  begin
    rf_next = rf_reg;
    rf_next.rda = rf_reg.cells[rd_addr_a];
    rf_next.rdb = rf_reg.cells[rd_addr_b];
    // Pair writes put the high byte half in the even register
    if (we && pair)
    begin
      rf_next.cells[{wr_addr[3:1], 1'b0}] = wr_data[2*W-1:W];
      rf_next.cells[{wr_addr[3:1], 1'b1}] = wr_data[W-1:0];
    end
    else if (we)
    begin
      rf_next.cells[wr_addr] = wr_data[W-1:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rf_reg <= '0;
    else
      rf_reg <= rf_next;
  end

  assign rd_data_a = rf_reg.rda;
  assign rd_data_b = rf_reg.rdb;
endmodule
`default_nettype wire

// file: logic/nibble_cpu_branch_io_exec.sv
// Execution core for a subset of a four-bit CPU: jumps, chip select, ports.
// Assumes program memory answers combinationally on prog_addr, and the
// test pin, program data and port input all arrive asynchronously.
//
// Contract
// RQ1: Condition 0001 jumps to second-word target when test input is low.
// RQ2: Unmet condition falls through to the next location in sequence.
// RQ3: Top condition bit inverts the test, so 1001 jumps on test high.
// RQ4: Chip select drives the register pair at subcycle two; first nibble picks program chip. Code sends even register at two, odd at three.
// RQ5: Top two bits of that first nibble name the data-memory chip.
// RQ6: Port read loads the selected program chip's port value into accumulator.
// RQ7: Load immediate puts its own low nibble into the accumulator.
// RQ8: Add uses the selected index register contents, not the field value.
// RQ9: Exchange swaps accumulator and selected index register in one step.
// RQ10: Increment-skip jumps unless the register held 15, then falls through.
// RQ11: Increment-skip target stays within the page of the following instruction.
// RQ12: Increment-skip leaves the accumulator untouched.
// RQ13: Rotates pass through carry in both directions.
// RQ14: Port write sends the accumulator to the selected data chip's port.
// RQ15: Fetch immediate pair loads the second word into the register pair.
// RQ16: Index register increments wrap modulo sixteen.
`timescale 1ns/10ps
`default_nettype none
module nibble_cpu_branch_io_exec (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic test_in,
  input wire logic [7:0] prog_data,
  input wire logic [3:0] port_in,
  output logic [11:0] prog_addr,
  output logic [3:0] bus_out,
  output logic bus_oe_n,
  output logic address_subcycle_two,
  output logic address_subcycle_three,
  output logic port_rd,
  output logic port_wr,
  output logic [3:0] prog_chip,
  output logic [1:0] data_chip,
  output logic [3:0] acc,
  output logic carry
);
  typedef struct packed {
    nibble_exec_pkg::phase_e ph;
    logic [3:0] cnt;
    logic second;
    logic [11:0] pc;
    logic [7:0] ir;
    logic [7:0] w2;
    logic [3:0] acc;
    logic carry;
    logic [11:0] prog_addr;
    logic [3:0] bus_out;
    logic bus_oe_n;
    logic sub_two;
    logic sub_three;
    logic port_rd;
    logic port_wr;
    logic [3:0] prog_chip;
    logic [1:0] data_chip;
    logic test_meta;
    logic test_sync;
    logic [7:0] prog_meta;
    logic [7:0] prog_sync;
    logic [3:0] port_meta;
    logic [3:0] port_sync;
  } core_s;

  core_s st_reg;
  core_s st_next;

  logic [3:0] rd_addr_a;
  logic [3:0] rd_addr_b;
  logic [3:0] rd_a;
  logic [3:0] rd_b;
  logic mem_we;
  logic mem_pair;
  logic [7:0] mem_wdata;
  logic [11:0] page_target;
  logic [4:0] add_sum;
  logic [4:0] acc_c;
  logic jump_cond;
  logic [3:0] op;
  logic [3:0] low;

  function automatic logic two_words(input logic [7:0] w);
    two_words = (w[7:4] == nibble_exec_pkg::OP_CONDITIONAL_JUMP)
      || (w[7:4] == nibble_exec_pkg::OP_INCREMENT_SKIP)
      || (w[7:4] == nibble_exec_pkg::OP_PAIR && !w[nibble_exec_pkg::PAIR_SEND_BIT]);
  endfunction

  assign op = st_reg.ir[7:4];
  assign low = st_reg.ir[3:0];
  // Pair ops read even and odd registers; single ops read the named one
  assign rd_addr_a = (op == nibble_exec_pkg::OP_PAIR) ? {low[3:1], 1'b0} : low;
  assign rd_addr_b = {low[3:1], 1'b1};
  // Page comes from the pc already past the second word
  assign page_target = {st_reg.pc[11:8], st_reg.w2}; // RQ11
  assign add_sum = 5'(st_reg.acc) + 5'(rd_a) + 5'(st_reg.carry); // RQ8
  assign acc_c = {st_reg.acc, st_reg.carry};
  assign jump_cond = low[nibble_exec_pkg::COND_INVERT_BIT] ^ // RQ3
    ((low[nibble_exec_pkg::COND_ACC_ZERO_BIT] && st_reg.acc == 4'h0)
    || (low[nibble_exec_pkg::COND_CARRY_BIT] && st_reg.carry)
    || (low[nibble_exec_pkg::COND_TEST_BIT] && !st_reg.test_sync)); // RQ1

  index_reg_file #(
    .DEPTH(nibble_exec_pkg::REG_CNT),
    .W(nibble_exec_pkg::NIB_W)
  ) u_regs (
    .ref_clk(ref_clk),
    .srst(srst),
    .rd_addr_a(rd_addr_a),
    .rd_addr_b(rd_addr_b),
    .rd_data_a(rd_a),
    .rd_data_b(rd_b),
    .we(mem_we),
    .pair(mem_pair),
    .wr_addr(low),
    .wr_data(mem_wdata)
  );

  always_comb
  begin
    st_next = st_reg;
    mem_we = 1'b0;
    mem_pair = 1'b0;
    mem_wdata = 8'h00;
    // Pins are only seen through the second flop of each synchroniser
    st_next.test_meta = test_in;
    st_next.test_sync = st_reg.test_meta;
    st_next.prog_meta = prog_data;
    st_next.prog_sync = st_reg.prog_meta;
    st_next.port_meta = port_in;
    st_next.port_sync = st_reg.port_meta;
    st_next.bus_oe_n = 1'b1;
    st_next.bus_out = 4'h0;
    st_next.sub_two = 1'b0;
    st_next.sub_three = 1'b0;
    st_next.port_wr = 1'b0;
    st_next.port_rd = 1'b0;
    case (st_reg.ph)
      nibble_exec_pkg::ph_addr:
      begin
        st_next.prog_addr = st_reg.pc;
        st_next.cnt = 4'h0;
        st_next.ph = nibble_exec_pkg::ph_wait;
      end
      nibble_exec_pkg::ph_wait:
      begin
        st_next.cnt = st_reg.cnt + 4'h1;
        // Waiting covers the memory path plus the two synchroniser flops
        if (st_reg.cnt == nibble_exec_pkg::FETCH_WAIT_CYC)
        begin
          st_next.pc = st_reg.pc + 12'h001; // RQ2
          if (!st_reg.second)
          begin
            st_next.ir = st_reg.prog_sync;
            st_next.second = two_words(st_reg.prog_sync);
            st_next.ph = two_words(st_reg.prog_sync) ? nibble_exec_pkg::ph_addr
              : nibble_exec_pkg::ph_read;
          end
          else
          begin
            st_next.w2 = st_reg.prog_sync;
            st_next.second = 1'b0;
            st_next.ph = nibble_exec_pkg::ph_read;
          end
        end
      end
      nibble_exec_pkg::ph_read:
      begin
        st_next.ph = nibble_exec_pkg::ph_exec;
      end
      nibble_exec_pkg::ph_exec:
      begin
        st_next.ph = nibble_exec_pkg::ph_addr;
        case (op)
          nibble_exec_pkg::OP_CONDITIONAL_JUMP:
          begin
            if (jump_cond)
              st_next.pc = page_target; // RQ1
          end
          nibble_exec_pkg::OP_PAIR:
          begin
            if (low[nibble_exec_pkg::PAIR_SEND_BIT])
            begin
              st_next.bus_out = rd_a; // RQ4
              st_next.bus_oe_n = 1'b0;
              st_next.sub_two = 1'b1;
              st_next.prog_chip = rd_a; // RQ4
              st_next.data_chip =
                rd_a[nibble_exec_pkg::DM_CHIP_HI:nibble_exec_pkg::DM_CHIP_LO]; // RQ5
              st_next.ph = nibble_exec_pkg::ph_send;
            end
            else
            begin
              mem_we = 1'b1; // RQ15
              mem_pair = 1'b1;
              mem_wdata = st_reg.w2;
            end
          end
          nibble_exec_pkg::OP_INCREMENT_SKIP:
          begin
            // Accumulator left alone so loops need not save it
            mem_we = 1'b1; // RQ12
            mem_wdata = {4'h0, rd_a + 4'h1}; // RQ16
            if (rd_a != 4'hF)
              st_next.pc = page_target; // RQ10
          end
          nibble_exec_pkg::OP_ADD:
          begin
            {st_next.carry, st_next.acc} = add_sum; // RQ8
          end
          nibble_exec_pkg::OP_EXCHANGE:
          begin
            st_next.acc = rd_a; // RQ9
            mem_we = 1'b1;
            mem_wdata = {4'h0, st_reg.acc};
          end
          nibble_exec_pkg::OP_LOAD_IMMEDIATE:
          begin
            st_next.acc = low; // RQ7
          end
          nibble_exec_pkg::OP_IO:
          begin
            if (low == nibble_exec_pkg::IO_WRITE_DATA_MEM_PORT)
            begin
              st_next.bus_out = st_reg.acc; // RQ14
              st_next.bus_oe_n = 1'b0;
              st_next.port_wr = 1'b1;
            end
            else if (low == nibble_exec_pkg::IO_READ_PROG_MEM_PORT)
            begin
              st_next.port_rd = 1'b1; // RQ6
              st_next.cnt = 4'h0;
              st_next.ph = nibble_exec_pkg::ph_port;
            end
          end
          nibble_exec_pkg::OP_ACC:
          begin
            if (low == nibble_exec_pkg::ACC_ROTATE_LEFT)
              {st_next.carry, st_next.acc} = acc_c; // RQ13
            else if (low == nibble_exec_pkg::ACC_ROTATE_RIGHT)
              {st_next.acc, st_next.carry} = {acc_c[0], acc_c[4:1]}; // RQ13
            else if (low == nibble_exec_pkg::ACC_COMPLEMENT_CARRY)
              st_next.carry = !st_reg.carry;
          end
          default:
          begin
            st_next.ph = nibble_exec_pkg::ph_addr;
          end
        endcase
      end
      nibble_exec_pkg::ph_send:
      begin
        st_next.bus_out = rd_b;
        st_next.bus_oe_n = 1'b0;
        st_next.sub_three = 1'b1;
        st_next.ph = nibble_exec_pkg::ph_addr;
      end
      nibble_exec_pkg::ph_port:
      begin
        // Strobe held while the chip's value crosses the synchroniser
        st_next.cnt = st_reg.cnt + 4'h1;
        st_next.port_rd = 1'b1;
        if (st_reg.cnt == nibble_exec_pkg::PORT_WAIT_CYC)
        begin
          st_next.acc = st_reg.port_sync; // RQ6
          st_next.port_rd = 1'b0;
          st_next.ph = nibble_exec_pkg::ph_addr;
        end
      end
      default:
      begin
        st_next.ph = nibble_exec_pkg::ph_addr;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_reg <= '0;
      st_reg.ph <= nibble_exec_pkg::ph_addr;
      st_reg.pc <= nibble_exec_pkg::PC_RESET;
      st_reg.acc <= nibble_exec_pkg::ACC_RESET;
      st_reg.carry <= nibble_exec_pkg::CARRY_RESET;
      st_reg.bus_oe_n <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign prog_addr = st_reg.prog_addr;
  assign bus_out = st_reg.bus_out;
  assign bus_oe_n = st_reg.bus_oe_n;
  assign address_subcycle_two = st_reg.sub_two;
  assign address_subcycle_three = st_reg.sub_three;
  assign port_rd = st_reg.port_rd;
  assign port_wr = st_reg.port_wr;
  assign prog_chip = st_reg.prog_chip;
  assign data_chip = st_reg.data_chip;
  assign acc = st_reg.acc;
  assign carry = st_reg.carry;

  // Checks
  logic ex;
  assign ex = (st_reg.ph == nibble_exec_pkg::ph_exec);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_send_first;
    address_subcycle_two && !bus_oe_n && bus_out == prog_chip
      && data_chip == bus_out[3:2];
  endsequence

  sequence s_send_second;
    address_subcycle_three && !bus_oe_n && !address_subcycle_two;
  endsequence

  a_jump_on_low: assert property ( // RQ1
    ex && op == nibble_exec_pkg::OP_CONDITIONAL_JUMP && low == 4'h1 && !st_reg.test_sync
    |=> st_reg.pc == $past(page_target))
    else $error("jump on low test not taken");

  a_jump_fall_through: assert property ( // RQ2
    ex && op == nibble_exec_pkg::OP_CONDITIONAL_JUMP && !jump_cond
    |=> st_reg.pc == $past(st_reg.pc) ##1 prog_addr == $past(st_reg.pc, 2))
    else $error("untaken jump did not fall through");

  a_jump_inverted: assert property ( // RQ3
    ex && op == nibble_exec_pkg::OP_CONDITIONAL_JUMP && low == 4'h9 && st_reg.test_sync
    |=> st_reg.pc == $past(page_target))
    else $error("inverted jump on high test not taken");

  a_select_send: assert property ( // RQ4
    ex && op == nibble_exec_pkg::OP_PAIR && low[0]
    |=> s_send_first and (bus_out == $past(rd_a)) ##1 s_send_second)
    else $error("chip select nibbles not sent in order");

  a_data_chip_num: assert property ( // RQ5
    $rose(address_subcycle_two) |-> data_chip == bus_out[3:2] ##1 $stable(data_chip))
    else $error("data chip number not taken from top bits");

  a_port_read: assert property ( // RQ6
    st_reg.ph == nibble_exec_pkg::ph_port && st_reg.cnt == nibble_exec_pkg::PORT_WAIT_CYC
    |=> acc == $past(st_reg.port_sync) && !port_rd)
    else $error("port value not loaded into accumulator");

  a_load_literal: assert property ( // RQ7
    ex && op == nibble_exec_pkg::OP_LOAD_IMMEDIATE |=> acc == $past(low))
    else $error("literal not loaded");

  a_add_register: assert property ( // RQ8
    ex && op == nibble_exec_pkg::OP_ADD |=> {carry, acc} == $past(add_sum))
    else $error("add did not use register contents");

  a_exchange_swap: assert property ( // RQ9
    ex && op == nibble_exec_pkg::OP_EXCHANGE |-> mem_we && mem_wdata[3:0] == acc
    ##1 acc == $past(rd_a))
    else $error("exchange did not swap");

  a_skip_loop: assert property ( // RQ10
    ex && op == nibble_exec_pkg::OP_INCREMENT_SKIP
    |=> st_reg.pc == ($past(rd_a) == 4'hF ? $past(st_reg.pc) : $past(page_target)))
    else $error("increment-skip branch wrong");

  a_skip_same_page: assert property ( // RQ11
    ex && op == nibble_exec_pkg::OP_INCREMENT_SKIP && rd_a != 4'hF
    |=> st_reg.pc[11:8] == $past(st_reg.pc[11:8]))
    else $error("increment-skip left its page");

  a_skip_keeps_acc: assert property ( // RQ12
    ex && op == nibble_exec_pkg::OP_INCREMENT_SKIP |=> $stable(acc))
    else $error("increment-skip changed accumulator");

  a_rotate_carry: assert property ( // RQ13
    ex && op == nibble_exec_pkg::OP_ACC && low == nibble_exec_pkg::ACC_ROTATE_RIGHT
    |=> {acc, carry} == {$past(acc_c[0]), $past(acc_c[4:1])})
    else $error("rotate right lost carry");

  a_port_write: assert property ( // RQ14
    ex && op == nibble_exec_pkg::OP_IO && low == nibble_exec_pkg::IO_WRITE_DATA_MEM_PORT
    |=> port_wr && !bus_oe_n && bus_out == $past(st_reg.acc) ##1 !port_wr)
    else $error("port write not driven");

  a_pair_load: assert property ( // RQ15
    ex && op == nibble_exec_pkg::OP_PAIR && !low[0]
    |-> mem_we && mem_pair && mem_wdata == st_reg.w2)
    else $error("pair load wrong");

  a_wrap_sixteen: assert property ( // RQ16
    ex && op == nibble_exec_pkg::OP_INCREMENT_SKIP && rd_a == 4'hF
    |-> mem_we && mem_wdata == 8'h00)
    else $error("increment did not wrap to zero");
endmodule
`default_nettype wire

// file: shared/nibble_exec_pkg.sv
// Constants shared by the nibble CPU execution block and its register file.
// Assumes program memory and I/O chips sit outside, behind unclocked pins.
`default_nettype none
package nibble_exec_pkg;
  // Widths
  localparam int PC_W = 12;
  localparam int WORD_W = 8;
  localparam int NIB_W = 4;
  localparam int REG_CNT = 16;

  // Upper nibble of the first instruction word
  localparam logic [3:0] OP_CONDITIONAL_JUMP = 4'h1;
  localparam logic [3:0] OP_PAIR = 4'h2;
  localparam logic [3:0] OP_INCREMENT_SKIP = 4'h7;
  localparam logic [3:0] OP_ADD = 4'h8;
  localparam logic [3:0] OP_EXCHANGE = 4'hB;
  localparam logic [3:0] OP_LOAD_IMMEDIATE = 4'hD;
  localparam logic [3:0] OP_IO = 4'hE;
  localparam logic [3:0] OP_ACC = 4'hF;

  // Lower nibble selectors for the I/O and accumulator groups
  localparam logic [3:0] IO_WRITE_DATA_MEM_PORT = 4'h1;
  localparam logic [3:0] IO_READ_PROG_MEM_PORT = 4'hA;
  localparam logic [3:0] ACC_COMPLEMENT_CARRY = 4'h3;
  localparam logic [3:0] ACC_ROTATE_LEFT = 4'h5;
  localparam logic [3:0] ACC_ROTATE_RIGHT = 4'h6;

  // Bit 0 of the pair opcode: 0 fetch immediate pair, 1 send chip select
  localparam int PAIR_SEND_BIT = 0;

  // Condition field bit positions
  localparam int COND_INVERT_BIT = 3;
  localparam int COND_ACC_ZERO_BIT = 2;
  localparam int COND_CARRY_BIT = 1;
  localparam int COND_TEST_BIT = 0;

  // Data-memory chip number field inside the first selected nibble
  localparam int DM_CHIP_HI = 3;
  localparam int DM_CHIP_LO = 2;

  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [3:0] ACC_RESET = 4'h0;
  localparam logic CARRY_RESET = 1'b0;

  // Timing: clock period in ns, wait counts in ref_clk cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [3:0] FETCH_WAIT_CYC = 4'h3;
  localparam logic [3:0] PORT_WAIT_CYC = 4'h3;

  typedef enum logic [5:0] {
    ph_addr = 6'h01,
    ph_wait = 6'h02,
    ph_read = 6'h04,
    ph_exec = 6'h08,
    ph_send = 6'h10,
    ph_port = 6'h20
  } phase_e;
endpackage
`default_nettype wire
